// File: shared/irq_bank_pkg.sv
// Package: register map, field layout, reset values and carriers of the interrupt enable bank
//
// Notes on behaviour
// - Vectoring happens only while global enable, control bit 7, is set.
// - Control bit 6 gates every source enabled in groups one to six.
// - Group one to six source vectors only with own, group and global enable.
// - Group zero source vectors with own and global enable, ignoring group enable.
// - Control bit 0 selects external edge: 1 rising, 0 falling; resets to 1.
// - Request flags set on their condition regardless of any enable bit.
// - External input comes from the pin chosen by the pin select register.
// - Group zero: bit 5 timer0, bit 4 pin change, bit 0 external pin.
// - Group one bits 7..0: timer1 gate, timer1, osc fail, clock switch, tuning, scan, crc, nvm.
// - Group two bits 6..0: ccp2, ccp1, timer6, timer4, timer2, timer3 gate, timer3.
// - Group three holds parameter/period enable pairs for pwm units four to one.
// - Reset clears global and group enables so no vectoring occurs.
// - Taking an interrupt flushes prefetch, clears global enable, pushes pc, loads vector.
// - Return from isr sets global enable and moves the bank back to its run state.
// - External flag sets on an edge of the selected polarity.
package irq_bank_pkg;

    // Word indices; printed offsets are not all multiples of four, so byte address is index times four
    localparam logic [11:0] IDX_CONTROL = 12'h00B;
    localparam logic [11:0] IDX_ENABLE0 = 12'h096;
    localparam logic [11:0] IDX_ENABLE1 = 12'h097;
    localparam logic [11:0] IDX_ENABLE2 = 12'h098;
    localparam logic [11:0] IDX_ENABLE3 = 12'h099;
    localparam logic [11:0] IDX_FLAGS = 12'h0A0;
    localparam logic [11:0] IDX_FLAG_CLEAR = 12'h0A1;
    localparam logic [11:0] IDX_PIN_SELECT = 12'h0A2;
    localparam logic [11:0] IDX_STATUS = 12'h0A3;
    localparam logic [11:0] IDX_IRQ_CLEAR = 12'h0A4;
    localparam logic [11:0] IDX_IRQ_ENABLE = 12'h0A5;

    localparam int GIE_BIT = 7;
    localparam int PERIPH_GROUP_IRQ_ENABLE_BIT = 6;
    localparam int EDGE_BIT = 0;
    localparam int G0_TIMER0_BIT = 5;
    localparam int G0_PINCHG_BIT = 4;
    localparam int G0_EXT_BIT = 0;

    // Writable masks per register
    localparam logic [7:0] CONTROL_MASK = 8'hC1;
    localparam logic [7:0] ENABLE0_MASK = 8'h31;
    localparam logic [7:0] ENABLE1_MASK = 8'hFF;
    localparam logic [7:0] ENABLE2_MASK = 8'h7F;
    localparam logic [7:0] ENABLE3_MASK = 8'hFF;

    localparam logic [7:0] CONTROL_RESET = 8'h01;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [15:0] VECTOR_ADDR = 16'h0004;

    // Local event bits
    localparam int EV_TAKEN = 0;
    localparam int EV_RETURN = 1;
    localparam int EV_EXT_EDGE = 2;
    localparam int EV_W = 3;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic vector_take;
        logic flush_prefetch;
        logic push_pc;
        logic [15:0] vector_addr;
    } core_cmd_t;

endpackage

// File: verilog/interrupt_enable_control_bank.sv
// Interrupt control and enable bank with APB registers and core vectoring request
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

module interrupt_enable_control_bank #(
    parameter int PIN_COUNT = 8,
    parameter int SEL_W = 3
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire irq_bank_pkg::apb_req_t apb_in,
    output irq_bank_pkg::apb_rsp_t apb_out,
    input wire logic [PIN_COUNT-1:0] ext_pins_in,
    input wire logic [7:0] group0_flags_in,
    input wire logic [7:0] group1_flags_in,
    input wire logic [7:0] group2_flags_in,
    input wire logic [7:0] group3_flags_in,
    input wire logic [7:0] group4_6_pending_in,
    input wire logic core_ready_in,
    input wire logic return_from_isr_in,
    output irq_bank_pkg::core_cmd_t core_out,
    output logic irq_out
);

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_ISR = 2'b10
    } core_state_t;

    typedef struct packed {
        core_state_t state;
        logic [7:0] control;
        logic [7:0] enable0;
        logic [7:0] enable1;
        logic [7:0] enable2;
        logic [7:0] enable3;
        logic ext_pin_irq_flag;
        logic ext_level;
        logic [SEL_W-1:0] ext_input_pin_select;
        logic [irq_bank_pkg::EV_W-1:0] status;
        logic [irq_bank_pkg::EV_W-1:0] irq_en;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        irq_bank_pkg::core_cmd_t cmd;
    } state_t;

    state_t cur_r;
    state_t cur_nxt;

    function automatic logic hit(input logic [31:0] addr, input logic [11:0] idx);
        hit = (addr[31:14] == 18'h0) && (addr[13:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    logic ext_sample;
    logic ext_edge;
    logic [7:0] g0_flags;
    logic group0_want;
    logic periph_want;
    logic want;
    logic access;
    logic wr;
    logic [7:0] wbyte;
    logic mapped;
    logic [31:0] rdata;
    logic [irq_bank_pkg::EV_W-1:0] events;

    always_comb begin
        ext_sample = ext_pins_in[cur_r.ext_input_pin_select];
        // Edge polarity follows the select bit
        if (cur_r.control[irq_bank_pkg::EDGE_BIT]) begin
            ext_edge = ext_sample && !cur_r.ext_level;
        end else begin
            ext_edge = !ext_sample && cur_r.ext_level;
        end
        g0_flags = group0_flags_in;
        g0_flags[irq_bank_pkg::G0_EXT_BIT] = cur_r.ext_pin_irq_flag;
        // Group zero skips the peripheral group enable
        group0_want = |(g0_flags & cur_r.enable0);
        // Groups one to six need the group enable too
        periph_want = cur_r.control[irq_bank_pkg::PERIPH_GROUP_IRQ_ENABLE_BIT] &&
            (|(group1_flags_in & cur_r.enable1) || |(group2_flags_in & cur_r.enable2) ||
             |(group3_flags_in & cur_r.enable3) || |group4_6_pending_in);
        want = cur_r.control[irq_bank_pkg::GIE_BIT] && (group0_want || periph_want);
        access = apb_in.psel && apb_in.penable;
        wr = access && apb_in.pwrite;
        wbyte = apb_in.pwdata[7:0];
        mapped = 1'b1;
        rdata = 32'h0;
        // Unimplemented bits read zero through the stored masks
        if (hit(apb_in.paddr, irq_bank_pkg::IDX_CONTROL)) begin
            rdata[7:0] = cur_r.control;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_ENABLE0)) begin
            rdata[7:0] = cur_r.enable0;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_ENABLE1)) begin
            rdata[7:0] = cur_r.enable1;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_ENABLE2)) begin
            rdata[7:0] = cur_r.enable2;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_ENABLE3)) begin
            rdata[7:0] = cur_r.enable3;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_FLAGS)) begin
            rdata[0] = cur_r.ext_pin_irq_flag;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_FLAG_CLEAR)) begin
            rdata = 32'h0;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_PIN_SELECT)) begin
            rdata[SEL_W-1:0] = cur_r.ext_input_pin_select;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_STATUS)) begin
            rdata[irq_bank_pkg::EV_W-1:0] = cur_r.status;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_IRQ_CLEAR)) begin
            rdata = 32'h0;
        end else if (hit(apb_in.paddr, irq_bank_pkg::IDX_IRQ_ENABLE)) begin
            rdata[irq_bank_pkg::EV_W-1:0] = cur_r.irq_en;
        end else begin
            mapped = 1'b0;
        end
    end

    always_comb begin
        cur_nxt = cur_r;
        events = '0;
        cur_nxt.ext_level = ext_sample;
        cur_nxt.cmd.vector_take = 1'b0;
        cur_nxt.cmd.flush_prefetch = 1'b0;
        cur_nxt.cmd.push_pc = 1'b0;
        cur_nxt.cmd.vector_addr = irq_bank_pkg::VECTOR_ADDR;
        // One-wait slave: registered answer the cycle after the access cycle, one-cycle pready pulse
        cur_nxt.pready = access && !cur_r.pready;
        cur_nxt.pslverr = access && !cur_r.pready && !mapped;
        if (access && !cur_r.pready && !apb_in.pwrite) begin
            cur_nxt.prdata = rdata;
        end
        if (wr && !cur_r.pready) begin
            if (hit(apb_in.paddr, irq_bank_pkg::IDX_CONTROL)) begin
                cur_nxt.control = wbyte & irq_bank_pkg::CONTROL_MASK;
            end
            if (hit(apb_in.paddr, irq_bank_pkg::IDX_ENABLE0)) begin
                cur_nxt.enable0 = wbyte & irq_bank_pkg::ENABLE0_MASK;
            end
            if (hit(apb_in.paddr, irq_bank_pkg::IDX_ENABLE1)) begin
                cur_nxt.enable1 = wbyte & irq_bank_pkg::ENABLE1_MASK;
            end
            if (hit(apb_in.paddr, irq_bank_pkg::IDX_ENABLE2)) begin
                cur_nxt.enable2 = wbyte & irq_bank_pkg::ENABLE2_MASK;
            end
            if (hit(apb_in.paddr, irq_bank_pkg::IDX_ENABLE3)) begin
                cur_nxt.enable3 = wbyte & irq_bank_pkg::ENABLE3_MASK;
            end
            if (hit(apb_in.paddr, irq_bank_pkg::IDX_FLAG_CLEAR) && wbyte[0]) begin
                cur_nxt.ext_pin_irq_flag = 1'b0;
            end
            if (hit(apb_in.paddr, irq_bank_pkg::IDX_PIN_SELECT)) begin
                cur_nxt.ext_input_pin_select = wbyte[SEL_W-1:0];
            end
            if (hit(apb_in.paddr, irq_bank_pkg::IDX_IRQ_CLEAR)) begin
                cur_nxt.status = cur_r.status & ~wbyte[irq_bank_pkg::EV_W-1:0];
            end
            if (hit(apb_in.paddr, irq_bank_pkg::IDX_IRQ_ENABLE)) begin
                cur_nxt.irq_en = wbyte[irq_bank_pkg::EV_W-1:0];
            end
        end
        // Flag sets regardless of enables; set beats a same-cycle clear
        if (ext_edge) begin
            cur_nxt.ext_pin_irq_flag = 1'b1;
            events[irq_bank_pkg::EV_EXT_EDGE] = 1'b1;
        end
        unique case (cur_r.state)
            ST_RUN: begin
                // Core must accept before the vector is issued
                if (want && core_ready_in) begin
                    cur_nxt.control[irq_bank_pkg::GIE_BIT] = 1'b0;
                    cur_nxt.cmd.vector_take = 1'b1;
                    cur_nxt.cmd.flush_prefetch = 1'b1;
                    cur_nxt.cmd.push_pc = 1'b1;
                    cur_nxt.state = ST_ISR;
                    events[irq_bank_pkg::EV_TAKEN] = 1'b1;
                end
            end
            ST_ISR: begin
                if (return_from_isr_in) begin
                    cur_nxt.control[irq_bank_pkg::GIE_BIT] = 1'b1;
                    cur_nxt.state = ST_RUN;
                    events[irq_bank_pkg::EV_RETURN] = 1'b1;
                end
            end
            default: begin
                cur_nxt.state = ST_RUN;
            end
        endcase
        cur_nxt.status = cur_nxt.status | events;
        if (srst_in) begin
            cur_nxt = '0;
            cur_nxt.state = ST_RUN;
            cur_nxt.control = irq_bank_pkg::CONTROL_RESET;
            cur_nxt.enable0 = irq_bank_pkg::ENABLE_RESET;
            cur_nxt.enable1 = irq_bank_pkg::ENABLE_RESET;
            cur_nxt.enable2 = irq_bank_pkg::ENABLE_RESET;
            cur_nxt.enable3 = irq_bank_pkg::ENABLE_RESET;
            cur_nxt.cmd.vector_addr = irq_bank_pkg::VECTOR_ADDR;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        cur_r <= cur_nxt;
    end

    assign apb_out.pready = cur_r.pready;
    assign apb_out.pslverr = cur_r.pslverr;
    assign apb_out.prdata = cur_r.prdata;
    assign core_out = cur_r.cmd;
    assign irq_out = |(cur_r.status & cur_r.irq_en);

endmodule

// File: bench/irq_bank_chk.sv
// Port checker for the interrupt enable bank
`timescale 1ns/1ps

module irq_bank_chk (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire irq_bank_pkg::apb_req_t apb_in,
    input wire irq_bank_pkg::apb_rsp_t apb_out,
    input wire logic core_ready_in,
    input wire irq_bank_pkg::core_cmd_t core_out,
    input wire logic irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    AST_TAKE_READY: assert property (core_out.vector_take |-> $past(core_ready_in))
        else $error("vector taken without core ready");
    AST_TAKE_ONCE: assert property (core_out.vector_take |=> !core_out.vector_take)
        else $error("vector take repeated");
    AST_TAKE_CMD: assert property (core_out.vector_take |-> core_out.flush_prefetch
        && core_out.push_pc && core_out.vector_addr == 16'h0004)
        else $error("take without flush, push or vector");
    AST_FLUSH_ONLY: assert property ($rose(core_out.flush_prefetch) |-> core_out.vector_take)
        else $error("flush without take");
    AST_RESET_QUIET: assert property (disable iff (1'b0) srst_in |=>
        !core_out.vector_take && !irq_out)
        else $error("activity after reset");
    AST_ERR_PAIR: assert property (apb_out.pslverr |-> apb_out.pready)
        else $error("error without ready");
    AST_ERR_ZERO: assert property (apb_out.pslverr && !apb_in.pwrite |->
        apb_out.prdata == 32'h00000000)
        else $error("refused read not zero");
    AST_UPPER_ZERO: assert property (apb_out.pready && !apb_in.pwrite |->
        apb_out.prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    AST_CTRL_GAPS: assert property (apb_out.pready && !apb_in.pwrite
        && apb_in.paddr == 32'h0000002C |-> apb_out.prdata[5:1] == 5'h00)
        else $error("control gap bits not zero");
endmodule

bind interrupt_enable_control_bank irq_bank_chk chk (.sys_clk_in(sys_clk_in),
    .srst_in(srst_in), .apb_in(apb_in), .apb_out(apb_out), .core_ready_in(core_ready_in),
    .core_out(core_out), .irq_out(irq_out));

// File: bench/interrupt_enable_control_bank_test.sv
// Self-checking bench for the interrupt enable bank
`timescale 1ns/1ps

module interrupt_enable_control_bank_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    irq_bank_pkg::apb_req_t req = '0;
    irq_bank_pkg::apb_rsp_t rsp;
    irq_bank_pkg::core_cmd_t core;
    logic [7:0] pins = 8'h00;
    logic [7:0] f [4] = '{default: 8'h00};
    logic [7:0] p46 = 8'h00;
    logic ready = 1'b0;
    logic ret = 1'b0;
    logic irq;
    int bad_count = 0;
    int checks_done = 0;
    integer seed = 32'hC479CD74;
    logic [31:0] q;
    logic e;
    logic t;
    logic [7:0] c;
    logic [7:0] pp;
    logic [7:0] en [4];
    logic [7:0] fv [4];
    logic [7:0] msk [5] = '{8'hC1, 8'h31, 8'hFF, 8'h7F, 8'hFF};
    int i;
    int s;
    int pn;

    always #10 clk = ~clk;

    interrupt_enable_control_bank uut (.sys_clk_in(clk), .srst_in(rst), .apb_in(req),
        .apb_out(rsp), .ext_pins_in(pins), .group0_flags_in(f[0]), .group1_flags_in(f[1]),
        .group2_flags_in(f[2]), .group3_flags_in(f[3]), .group4_6_pending_in(p46),
        .core_ready_in(ready), .return_from_isr_in(ret), .core_out(core), .irq_out(irq));

    function automatic logic [11:0] ix(int n);
        ix = (n == 0) ? 12'h00B : 12'(12'h095 + n);
    endfunction

    // Group zero bypasses the group enable
    function automatic logic want(logic [7:0] k, logic [7:0] m [4], logic [7:0] g [4],
        logic [7:0] p);
        want = k[7] && ((|(m[0] & g[0] & 8'h30)) || (k[6] && ((|(m[1] & g[1]))
            || (|(m[2] & g[2] & 8'h7F)) || (|(m[3] & g[3])) || (|p))));
    endfunction

    task automatic end_sim();
        $display("Checks %0d, errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // Waits on pready without assuming the slave latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] r, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= {18'h00000, a, 2'b00};
        req.pwdata <= {24'h000000, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        // A slave that never answers counts as a mismatch
        if (rsp.pready !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: no pready", $time);
        end
        r = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic try_take(output logic tk);
        tk = 1'b0;
        ready <= 1'b1;
        repeat (3) begin
            @(posedge clk);
            if (core.vector_take === 1'b1) tk = 1'b1;
        end
        ready <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, ix(i), 8'h00, q, e);
            chk(q, (i == 0) ? 32'h00000001 : 32'h00000000);
        end
        for (i = 0; i < 5; i++) begin
            apb(1'b1, ix(i), 8'hFF, q, e);
            apb(1'b0, ix(i), 8'h00, q, e);
            chk(q, {24'h000000, msk[i]});
        end
        for (i = 0; i < 5; i++) apb(1'b1, ix(i), 8'h00, q, e);
        apb(1'b0, 12'h050, 8'h00, q, e);
        chk(q, 32'h00000000);
        chk(32'(e), 32'h00000001);
        repeat (40) begin
            c = $random(seed);
            c = (c & 8'hC0) | 8'h01;
            pp = (($random(seed) & 3) == 0) ? 8'h10 : 8'h00;
            p46 <= pp;
            for (i = 0; i < 4; i++) begin
                en[i] = $random(seed);
                fv[i] = $random(seed);
                f[i] <= fv[i];
            end
            en[0] = en[0] & 8'h30;
            for (i = 0; i < 4; i++) apb(1'b1, ix(i + 1), en[i], q, e);
            apb(1'b1, ix(0), c, q, e);
            try_take(t);
            chk(32'(t), 32'(want(c, en, fv, pp)));
            if (t) begin
                apb(1'b0, ix(0), 8'h00, q, e);
                chk(32'(q[7]), 32'h00000000);
                ret <= 1'b1;
                @(posedge clk);
                ret <= 1'b0;
                apb(1'b0, ix(0), 8'h00, q, e);
                chk(32'(q[7]), 32'h00000001);
            end
        end
        f <= '{default: 8'h00};
        p46 <= 8'h00;
        for (i = 0; i < 5; i++) apb(1'b1, ix(i), 8'h00, q, e);
        // Unselected neighbour pin sees the wanted edge and must be ignored
        for (s = 0; s < 2; s++) begin
            pn = 3 + 2 * s;
            pins[pn] <= s[0];
            pins[pn ^ 1] <= !s[0];
            apb(1'b1, ix(0), {7'h00, s[0]}, q, e);
            apb(1'b1, 12'h0A2, 8'(pn), q, e);
            apb(1'b1, 12'h0A1, 8'h01, q, e);
            pins[pn] <= !s[0];
            pins[pn ^ 1] <= s[0];
            repeat (3) @(posedge clk);
            apb(1'b0, 12'h0A0, 8'h00, q, e);
            chk(q, 32'h00000000);
            pins[pn] <= s[0];
            repeat (3) @(posedge clk);
            apb(1'b0, 12'h0A0, 8'h00, q, e);
            chk(q, 32'h00000001);
        end
        apb(1'b1, ix(1), 8'h01, q, e);
        apb(1'b1, ix(0), 8'h81, q, e);
        try_take(t);
        chk(32'(t), 32'h00000001);
        apb(1'b0, 12'h0A3, 8'h00, q, e);
        chk(32'(q[2:0] & 3'b101), 32'h00000005);
        apb(1'b1, 12'h0A5, 8'h01, q, e);
        chk(32'(irq), 32'h00000001);
        apb(1'b1, 12'h0A5, 8'h00, q, e);
        chk(32'(irq), 32'h00000000);
        apb(1'b1, 12'h0A5, 8'h01, q, e);
        apb(1'b1, 12'h0A4, 8'h01, q, e);
        chk(32'(irq), 32'h00000000);
        // Mid-run reset must bring the control register back
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, ix(0), 8'h00, q, e);
        chk(q, 32'h00000001);
        chk(32'(irq), 32'h00000000);
        end_sim();
    end
endmodule
